// File: design/fault_status_defines.vh
`ifndef FAULT_STATUS_DEFINES_VH
`define FAULT_STATUS_DEFINES_VH

// Register indices as printed; byte address is four times the index
`define IDX_MINOR_FLAG      4'h5
`define IDX_MAJOR_CODE      4'h6
`define ADDR_MINOR_FLAG     8'h14
`define ADDR_MAJOR_CODE     8'h18
`define ADDR_CONTROL        8'h00
`define ADDR_CLASS          8'h04
`define ADDR_IRQ_STATUS     8'h20
`define ADDR_IRQ_MASK       8'h24

// Minor flag word bit positions
`define BIT_CTRL_ERR        2
`define BIT_FAULT_IN_FAULT  3
`define BIT_RETENTIVE_LOST  8
`define BIT_TIMED_INT_LOST  10
`define BIT_FILTER_MOD      13
`define MINOR_WRITABLE      16'h250c

// Interrupt status bit positions
`define IRQ_MAJOR           0
`define IRQ_CTRL_ERR        1
`define IRQ_FAULT_IN_FAULT  2
`define IRQ_RETENTIVE_LOST  3
`define IRQ_TIMED_INT_LOST  4
`define IRQ_FILTER_MOD      5
`define IRQ_WIDTH           6

// Major error codes raised by this block
`define CODE_MINOR_AT_END   16'h0020
`define CODE_RETENTIVE_LOST 16'h0005

// Fault classes and code categories
`define CLASS_NON_USER      2'h0
`define CLASS_NON_RECOV     2'h1
`define CLASS_RECOV         2'h2
`define CAT_POWERUP         2'h0
`define CAT_GOING_TO_RUN    2'h1
`define CAT_RUN             2'h2
`define CAT_DOWNLOAD        2'h3

// Reset values
`define RESET_MINOR         16'h0000
`define RESET_CODE          16'h0000
`define RESET_IRQ_MASK      6'h00

`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// File: design/controller_fault_status_logic.v
`timescale 1ns/1ps
`include "fault_status_defines.vh"

// Function
// [RQ1] Control-word error sets control-register error flag
// [RQ2] Flag still set at scan end: code 0020
// [RQ3] Program tests flag and clears it itself
// [RQ4] Major error inside fault routine sets flag
// [RQ5] Retentive loss sets flag until cleared
// [RQ6] Retentive flag set faults before first scan
// [RQ7] Timed interrupt overrun while pending sets flag
// [RQ8] Filter selection adjusted sets flag
// [RQ9] Declared major error writes its code
// [RQ10] Code word never cleared by hardware
// [RQ11] Program writes code then sets halted
// [RQ12] Each code belongs to one class
// [RQ13] Each code belongs to one category
// [RQ14] Recoverable fault cleared by resetting halted bit
// [RQ15] Non-user fault stops program, no routine
// [RQ16] Reserved flag bits read zero, ignore writes
// [RQ17] Code and halted update in same cycle
module controller_fault_status_logic (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        control_word_error,
	input  wire        end_of_scan,
	input  wire        major_error_event,
	input  wire [15:0] major_error_code_in,
	input  wire        in_fault_routine,
	input  wire        retentive_data_lost,
	input  wire        before_first_scan,
	input  wire        timed_interrupt_expired,
	input  wire        timed_interrupt_busy,
	input  wire        timed_interrupt_pending,
	input  wire        filter_selection_adjusted,
	output wire        major_error_halted,
	output wire [15:0] major_error_code,
	output wire        run_fault_routine,
	output wire        stop_program,
	output wire        irq
);

	// Bus channel state and the fault registers themselves
	reg        awready_reg;
	reg        wready_reg;
	reg        bvalid_reg;
	reg [1:0]  bresp_reg;
	reg        arready_reg;
	reg        rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0]  rresp_reg;
	reg [7:0]  wr_addr_reg;
	reg [31:0] wr_data_reg;
	reg [3:0]  wr_strb_reg;
	reg        aw_have_reg;
	reg        w_have_reg;
	reg [15:0] minor_reg;
	reg [15:0] code_reg;
	reg        halted_reg;
	reg        stop_reg;
	reg        routine_reg;
	reg        irq_reg;
	reg [`IRQ_WIDTH-1:0] irq_status_reg;
	reg [`IRQ_WIDTH-1:0] irq_mask_reg;

	// Next values and decode results, all combinational
	reg [15:0] minor_next;
	reg [15:0] code_next;
	reg        halted_next;
	reg        declare;
	reg [15:0] declare_code;
	reg [15:0] wr_mask;
	reg [`IRQ_WIDTH-1:0] irq_set;
	reg [`IRQ_WIDTH-1:0] irq_status_next;
	reg [31:0] rd_data;
	reg        rd_ok;

	// A write lands only when both halves are in and no response waits,
	// so a slow response taker cannot lose a second write
	wire wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	wire rd_fire = s_axi_arvalid && arready_reg;

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign major_error_halted = halted_reg;
	assign major_error_code   = code_reg;
	assign run_fault_routine  = routine_reg;
	assign stop_program       = stop_reg;
	assign irq                = irq_reg;

	// Fault class of a code; unknown codes are application faults
	function [1:0] code_class;
		input [15:0] c;
		begin
			case (c)
			16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h0009,
			16'h0010, 16'h0004, 16'h0031, 16'h0038:
				code_class = `CLASS_NON_USER;
			16'h0022, 16'h0024, 16'h0025, 16'h0027, 16'h002a,
			16'h002b, 16'h0030, 16'h0035, 16'h0040:
				code_class = `CLASS_NON_RECOV;
			default:
				code_class = `CLASS_RECOV;
			endcase
		end
	endfunction

	// Category of a code by the phase in which it arises
	function [1:0] code_category;
		input [15:0] c;
		begin
			case (c)
			16'h0001, 16'h0002, 16'h0003, 16'h0008, 16'h0009:
				code_category = `CAT_POWERUP;
			16'h0005, 16'h0010, 16'h0016:
				code_category = `CAT_GOING_TO_RUN;
			default:
				if (c >= 16'h0004 && c <= 16'h004f)
					code_category = `CAT_RUN;
				else
					code_category = `CAT_DOWNLOAD;
			endcase
		end
	endfunction

	// Byte-lane mask for the 16-bit registers
	function [15:0] lane_mask;
		input [3:0] s;
		begin
			lane_mask = {{8{s[1]}}, {8{s[0]}}};
		end
	endfunction

	// Major error source selection; core errors take priority
	always @* begin
		declare = 1'b0;
		declare_code = code_reg;
		if (major_error_event) begin
			declare = 1'b1;
			declare_code = major_error_code_in;
		end else if (end_of_scan && minor_reg[`BIT_CTRL_ERR]) begin
			declare = 1'b1; // [RQ2]
			declare_code = `CODE_MINOR_AT_END;
		end else if (before_first_scan &&
		             minor_reg[`BIT_RETENTIVE_LOST]) begin
			declare = 1'b1; // [RQ6]
			declare_code = `CODE_RETENTIVE_LOST;
		end else if (wr_fire && wr_addr_reg == `ADDR_CONTROL &&
		             wr_strb_reg[0] && wr_data_reg[0] && !halted_reg) begin
			declare = 1'b1; // [RQ11]
			declare_code = code_reg;
		end
	end

	// Flag word, code and halted next values; hardware sets beat writes
	always @* begin
		wr_mask = lane_mask(wr_strb_reg) & `MINOR_WRITABLE; // [RQ16]
		minor_next = minor_reg;
		code_next = code_reg;
		halted_next = halted_reg;
		if (wr_fire && wr_addr_reg == `ADDR_MINOR_FLAG)
			minor_next = (minor_reg & ~wr_mask) |
			             (wr_data_reg[15:0] & wr_mask); // [RQ3]
		if (wr_fire && wr_addr_reg == `ADDR_MAJOR_CODE)
			code_next = (code_reg & ~lane_mask(wr_strb_reg)) |
			            (wr_data_reg[15:0] & lane_mask(wr_strb_reg));
		// Only a recoverable fault may be cleared by software
		if (wr_fire && wr_addr_reg == `ADDR_CONTROL && wr_strb_reg[0] &&
		    !wr_data_reg[0] && in_fault_routine &&
		    code_class(code_reg) == `CLASS_RECOV)
			halted_next = 1'b0; // [RQ14]
		if (control_word_error)
			minor_next[`BIT_CTRL_ERR] = 1'b1; // [RQ1]
		if (declare && halted_reg && in_fault_routine)
			minor_next[`BIT_FAULT_IN_FAULT] = 1'b1; // [RQ4]
		if (retentive_data_lost)
			minor_next[`BIT_RETENTIVE_LOST] = 1'b1; // [RQ5]
		if (timed_interrupt_expired && timed_interrupt_busy &&
		    timed_interrupt_pending)
			minor_next[`BIT_TIMED_INT_LOST] = 1'b1; // [RQ7]
		if (filter_selection_adjusted)
			minor_next[`BIT_FILTER_MOD] = 1'b1; // [RQ8]
		// Code and halted move together; code only changes by overwrite
		if (declare) begin
			code_next = declare_code; // [RQ9] [RQ10]
			halted_next = 1'b1; // [RQ17]
		end
	end

	// Interrupt events: set wins over a same-cycle write-one clear
	always @* begin
		irq_set = {`IRQ_WIDTH{1'b0}};
		irq_set[`IRQ_MAJOR] = declare;
		irq_set[`IRQ_CTRL_ERR] = control_word_error;
		irq_set[`IRQ_FAULT_IN_FAULT] = declare && halted_reg &&
		                               in_fault_routine;
		irq_set[`IRQ_RETENTIVE_LOST] = retentive_data_lost;
		irq_set[`IRQ_TIMED_INT_LOST] = timed_interrupt_expired &&
		                               timed_interrupt_busy &&
		                               timed_interrupt_pending;
		irq_set[`IRQ_FILTER_MOD] = filter_selection_adjusted;
		irq_status_next = irq_status_reg;
		if (wr_fire && wr_addr_reg == `ADDR_IRQ_STATUS && wr_strb_reg[0])
			irq_status_next = irq_status_reg &
			                  ~wr_data_reg[`IRQ_WIDTH-1:0];
		irq_status_next = irq_status_next | irq_set;
	end

	// Read decode; unmapped addresses answer SLVERR with zero data
	always @* begin
		rd_data = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
		`ADDR_CONTROL:
			rd_data = {30'h00000000, stop_reg, halted_reg};
		`ADDR_CLASS:
			rd_data = {28'h0000000, code_category(code_reg),
			           code_class(code_reg)}; // [RQ12] [RQ13]
		`ADDR_MINOR_FLAG:
			rd_data = {16'h0000, minor_reg}; // [RQ16]
		`ADDR_MAJOR_CODE:
			rd_data = {16'h0000, code_reg};
		`ADDR_IRQ_STATUS:
			rd_data = {26'h0000000, irq_status_reg};
		`ADDR_IRQ_MASK:
			rd_data = {26'h0000000, irq_mask_reg};
		default:
			rd_ok = 1'b0;
		endcase
	end

	// Write channels: address and data taken separately, any order
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 32'h00000000;
			wr_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else begin
			awready_reg <= !aw_have_reg && !(s_axi_awvalid && awready_reg);
			wready_reg <= !w_have_reg && !(s_axi_wvalid && wready_reg);
			if (s_axi_awvalid && awready_reg) begin
				aw_have_reg <= 1'b1;
				wr_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg) begin
				w_have_reg <= 1'b1;
				wr_data_reg <= s_axi_wdata;
				wr_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				case (wr_addr_reg)
				`ADDR_CONTROL, `ADDR_MINOR_FLAG, `ADDR_MAJOR_CODE,
				`ADDR_IRQ_STATUS, `ADDR_IRQ_MASK, `ADDR_CLASS:
					bresp_reg <= `RESP_OKAY;
				default:
					bresp_reg <= `RESP_SLVERR;
				endcase
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read channel: one read in flight, data registered at acceptance
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RESP_OKAY;
		end else begin
			arready_reg <= !rvalid_reg && !rd_fire;
			if (rd_fire) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_data;
				rresp_reg <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// Fault state; a stop for a non-user fault holds until reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			minor_reg <= `RESET_MINOR;
			code_reg <= `RESET_CODE;
			halted_reg <= 1'b0;
			stop_reg <= 1'b0;
			routine_reg <= 1'b0;
			irq_status_reg <= {`IRQ_WIDTH{1'b0}};
			irq_mask_reg <= `RESET_IRQ_MASK;
			irq_reg <= 1'b0;
		end else begin
			minor_reg <= minor_next;
			code_reg <= code_next;
			halted_reg <= halted_next;
			routine_reg <= 1'b0;
			if (declare) begin
				if (code_class(declare_code) == `CLASS_NON_USER)
					stop_reg <= 1'b1; // [RQ15]
				else
					routine_reg <= 1'b1; // [RQ14]
			end
			irq_status_reg <= irq_status_next;
			if (wr_fire && wr_addr_reg == `ADDR_IRQ_MASK && wr_strb_reg[0])
				irq_mask_reg <= wr_data_reg[`IRQ_WIDTH-1:0];
			irq_reg <= |(irq_status_next & irq_mask_reg);
		end
	end

endmodule

// File: bench/fault_status_assertions.sv
`timescale 1ns/1ps
// Ties the fault outputs to their causes at the core and bus inputs
module fault_status_assertions (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awready,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        major_error_event,
	input logic [15:0] major_error_code_in,
	input logic        end_of_scan,
	input logic        before_first_scan,
	input logic        major_error_halted,
	input logic [15:0] major_error_code,
	input logic        run_fault_routine,
	input logic        stop_program
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Codes that halt the program outright instead of running the routine
	wire non_user = major_error_code inside {16'h0001, 16'h0002,
		16'h0003, 16'h0004, 16'h0008, 16'h0009, 16'h0010, 16'h0031,
		16'h0038};

	event_code_a: assert property (
		major_error_event |=> major_error_halted &&
		major_error_code == $past(major_error_code_in))
		else $error("declared code not stored");
	code_cause_a: assert property (
		$changed(major_error_code) |-> $rose(s_axi_bvalid) ||
		$past(major_error_event) || $past(end_of_scan) ||
		$past(before_first_scan))
		else $error("code word changed with no cause");
	stop_sticky_a: assert property (
		stop_program |=> stop_program)
		else $error("stop released without reset");
	stop_class_a: assert property (
		$rose(stop_program) |-> non_user)
		else $error("stop raised for a user fault");
	routine_ok_a: assert property (
		run_fault_routine |-> major_error_halted && !non_user)
		else $error("routine requested for wrong class");
	declare_react_a: assert property (
		$rose(major_error_halted) |-> ##[0:2]
		(run_fault_routine || stop_program))
		else $error("halt without routine or stop");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_busy_a: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
endmodule

bind controller_fault_status_logic fault_status_assertions chk_i (.*);

// File: bench/user_program_model.sv
`timescale 1ns/1ps
// The user program's view: register accesses over the bus, one at a time
module user_program_model (
	input  logic        aclk,
	output logic [7:0]  s_axi_awaddr = 0,
	output logic        s_axi_awvalid = 0,
	input  logic        s_axi_awready,
	output logic [31:0] s_axi_wdata = 0,
	output logic [3:0]  s_axi_wstrb = 0,
	output logic        s_axi_wvalid = 0,
	input  logic        s_axi_wready,
	input  logic [1:0]  s_axi_bresp,
	input  logic        s_axi_bvalid,
	output logic        s_axi_bready = 0,
	output logic [7:0]  s_axi_araddr = 0,
	output logic        s_axi_arvalid = 0,
	input  logic        s_axi_arready,
	input  logic [31:0] s_axi_rdata,
	input  logic [1:0]  s_axi_rresp,
	input  logic        s_axi_rvalid,
	output logic        s_axi_rready = 0
);
	// Write; released payload is inverted so stale values are never reused
	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 0;
				s_axi_wdata <= ~v;
			end
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask

	// Read; rready is held until the answer is sampled
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 0;
				s_axi_araddr <= ~a;
			end
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
endmodule

// File: bench/controller_fault_status_logic_tb_top.sv
`timescale 1ns/1ps
`include "fault_status_defines.vh"
module controller_fault_status_logic_tb_top;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [6:0]  ev = 0;
	logic        in_fault_routine = 0;
	logic        timed_interrupt_busy = 0;
	logic        timed_interrupt_pending = 0;
	logic [15:0] major_error_code_in = 0;
	logic [15:0] major_error_code;
	logic        major_error_halted, run_fault_routine, stop_program, irq;
	int          err_total = 0;
	int          n_checks = 0;
	int          n_rt = 0;

	always #2.5 aclk = ~aclk;

	// Core event pulses share one vector so a scenario fires several at once
	controller_fault_status_logic uut (
		.*,
		.control_word_error       (ev[0]),
		.end_of_scan              (ev[1]),
		.major_error_event        (ev[2]),
		.retentive_data_lost      (ev[3]),
		.before_first_scan        (ev[4]),
		.timed_interrupt_expired  (ev[5]),
		.filter_selection_adjusted(ev[6])
	);
	user_program_model pm (.*);

	// Routine requests are one-cycle pulses, so count them as they pass
	always @(posedge aclk) begin
		if (run_fault_routine === 1'b1)
			n_rt++;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task rv(input logic [7:0] a, input logic [31:0] e);
		pm.rd(a, d, r);
		chk(d, e);
	endtask
	task w(input logic [7:0] a, input logic [31:0] v);
		pm.wr(a, v, r);
		repeat (2) @(posedge aclk);
	endtask
	task pulse(input logic [6:0] m);
		@(posedge aclk);
		ev <= m;
		@(posedge aclk);
		ev <= 0;
		repeat (3) @(posedge aclk);
	endtask
	task rst;
		@(posedge aclk);
		aresetn <= 0;
		in_fault_routine <= 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		n_rt = 0;
		@(posedge aclk);
	endtask

	task t_regs;
		rst;
		rv(`ADDR_CONTROL, 0);
		rv(`ADDR_MAJOR_CODE, `RESET_CODE);
		rv(`ADDR_IRQ_MASK, 0);
		rv(8'h40, 0);
		chk(r, `RESP_SLVERR);
		pm.wr(8'h40, 1, r);
		chk(r, `RESP_SLVERR);
		w(`ADDR_MINOR_FLAG, 32'hffff);
		rv(`ADDR_MINOR_FLAG, `MINOR_WRITABLE);
	endtask
	task t_ctrl;
		rst;
		pulse(7'h01);
		rv(`ADDR_MINOR_FLAG, 32'h4);
		pulse(7'h02);
		chk(major_error_halted, 1);
		chk(major_error_code, `CODE_MINOR_AT_END);
		chk({n_rt[0], stop_program}, 2'b10);
		rv(`ADDR_CLASS, {`CAT_RUN, `CLASS_RECOV});
		w(`ADDR_CONTROL, 0);
		chk(major_error_halted, 1);
		in_fault_routine <= 1;
		w(`ADDR_CONTROL, 0);
		chk(major_error_halted, 0);
		rv(`ADDR_MAJOR_CODE, `CODE_MINOR_AT_END);
		in_fault_routine <= 0;
		w(`ADDR_MINOR_FLAG, 0);
		pulse(7'h02);
		chk(major_error_halted, 0);
	endtask
	task t_flags;
		rst;
		timed_interrupt_busy <= 1;
		pulse(7'h20);
		rv(`ADDR_MINOR_FLAG, 0);
		timed_interrupt_pending <= 1;
		pulse(7'h68);
		rv(`ADDR_MINOR_FLAG, 32'h2500);
		rv(`ADDR_IRQ_STATUS, 32'h38);
		chk(irq, 0);
		w(`ADDR_IRQ_MASK, 32'h20);
		chk(irq, 1);
		w(`ADDR_IRQ_STATUS, 32'h20);
		rv(`ADDR_IRQ_STATUS, 32'h18);
		chk(irq, 0);
	endtask
	task t_retain;
		rst;
		pulse(7'h10);
		chk(major_error_halted, 0);
		pulse(7'h08);
		pulse(7'h10);
		chk(major_error_code, `CODE_RETENTIVE_LOST);
		rv(`ADDR_CLASS, {`CAT_GOING_TO_RUN, `CLASS_RECOV});
	endtask
	// Power-up and download categories and the non-recoverable class, which the other scenarios never reach
	task t_classes;
		rst;
		w(`ADDR_MAJOR_CODE, 32'h0001);
		rv(`ADDR_CLASS, {`CAT_POWERUP, `CLASS_NON_USER});
		w(`ADDR_MAJOR_CODE, 32'h0100);
		rv(`ADDR_CLASS, {`CAT_DOWNLOAD, `CLASS_RECOV});
		w(`ADDR_MAJOR_CODE, 32'h0022);
		w(`ADDR_CONTROL, 1);
		chk({n_rt[0], stop_program, major_error_halted}, 3'b101);
		in_fault_routine <= 1;
		w(`ADDR_CONTROL, 0);
		chk(major_error_halted, 1);
		rv(`ADDR_CLASS, {`CAT_RUN, `CLASS_NON_RECOV});
	endtask
	task t_user;
		rst;
		w(`ADDR_MAJOR_CODE, 32'h0042);
		chk(major_error_halted, 0);
		w(`ADDR_CONTROL, 1);
		chk({major_error_halted, major_error_code}, 17'h10042);
		chk(n_rt, 1);
	endtask
	task t_nested;
		t_user;
		in_fault_routine <= 1;
		major_error_code_in <= 16'h0004;
		pulse(7'h04);
		chk({stop_program, major_error_code}, 17'h10004);
		chk(n_rt, 1);
		rv(`ADDR_MINOR_FLAG, 32'h8);
		rv(`ADDR_CLASS, {`CAT_RUN, `CLASS_NON_USER});
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		t_regs;
		t_ctrl;
		t_flags;
		t_retain;
		t_classes;
		t_nested;
		wrap_up;
	end
	// The run needs about three hundred cycles; this leaves ample margin
	initial begin
		#20000;
		err_total++;
		wrap_up;
	end
endmodule
